// File: design/awh_top.sv
// Overview of operation
// - halt opcode with wake enable set enters auto-wake halt, not plain halt
// - in auto-wake halt the wake oscillator runs and clocks the wake counter
// - wake clock divided by 64 then by prescale; duration adds oscillator start
// - on expiry hardware sets the wake flag and wakes the device
// - main oscillator restarts at once; 256 cycles pass before interrupt service
// - reading control/status clears the wake flag and its interrupt
// - writes to flag bit 2 leave the flag unchanged
// - measure bit in run mode routes wake clock to timer capture input
// - measure bit 1 also switches the wake oscillator on while set
// - halt entry clears core interrupt mask; pending interrupt wakes at once
// - reset or exit-capable interrupt also leaves auto-wake halt
// - in halt main oscillator stops and peripherals lose their clock
// - with watchdog on, option bit decides if halt gives watchdog reset
// - enable bit 0 is only set and cleared by software
// - prescale value is the dividing factor directly, 1 to 255
// - a write of 00h is ignored and the previous prescale kept
// - with multiplier enabled its clock is ready after an extra start delay
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "awh_cfg.svh"

module awh_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [8:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic halt_exec_i,
  input wire logic irq_pending_i,
  input wire logic exit_irq_i,
  input wire logic watchdog_en_i,
  input wire logic watchdog_halt_option_i,
  input wire logic pll_en_i,
  input wire logic wake_osc_clock_i,
  output logic wake_osc_en_o,
  output logic main_osc_en_o,
  output logic periph_clk_en_o,
  output logic core_run_o,
  output logic pll_ready_o,
  output logic auto_wake_halt_mode_o,
  output logic wake_irq_o,
  output logic int_mask_clear_o,
  output logic watchdog_reset_o,
  output logic capture_clk_o
);

  localparam logic [8:0] StabLast = 9'(`AWH_STAB_CYCLES - 1);
  localparam logic [8:0] PllLast = 9'(`AWH_PLL_START_CYCLES - 1);

  awh_pkg::awh_state_type state_q;
  awh_pkg::awh_state_type state_d;
  logic [8:0] wait_cnt_q;
  logic [7:0] wake_prescale_q;
  logic en_q;
  logic measure_q;
  logic wake_flag_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic osc_q;
  logic capture_q;
  logic mask_clr_q;
  logic wdg_rst_q;
  logic access_w;
  logic done_w;
  logic wr_w;
  logic rd_clr_w;
  logic tick_w;
  logic expire_w;
  logic wdg_trip_w;
  logic in_awh_w;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic logic hit_reg(input logic [8:0] adr, input logic [6:0] idx);
    hit_reg = (adr[8:2] == idx);
  endfunction

  function automatic logic [7:0] read_reg(input logic [8:0] adr, input logic [7:0] pre,
                                          input logic fl, input logic me, input logic en);
    logic [7:0] v;
    v = 8'h00;
    if (hit_reg(adr, `AWH_PRESCALE_IDX)) begin
      v = pre;
    end else if (hit_reg(adr, `AWH_CSR_IDX)) begin
      v[`AWH_CSR_FLAG_BIT] = fl;
      v[`AWH_CSR_MEAS_BIT] = me;
      v[`AWH_CSR_EN_BIT] = en;
    end
    read_reg = v;
  endfunction

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // one wait state: ack one cycle after the strobe, unmapped reads give zero
  assign access_w = wb_cyc_i && wb_stb_i;
  assign done_w = access_w && ack_q;
  assign wr_w = done_w && wb_we_i && wb_sel_i[0];
  assign rd_clr_w = done_w && !wb_we_i && hit_reg(wb_adr_i, `AWH_CSR_IDX);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access_w && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (access_w && !ack_q) begin
      dat_q <= {24'h00_0000, read_reg(wb_adr_i, wake_prescale_q, wake_flag_q, measure_q, en_q)};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  // bits 7:3 are not stored, so stray writes there cannot steer anything
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      measure_q <= 1'b0;
    end else if (wr_w && hit_reg(wb_adr_i, `AWH_CSR_IDX)) begin
      en_q <= wb_dat_i[`AWH_CSR_EN_BIT];
      measure_q <= wb_dat_i[`AWH_CSR_MEAS_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_prescale_q <= `AWH_PRESCALE_RST;
    end else if (wr_w && hit_reg(wb_adr_i, `AWH_PRESCALE_IDX)
                 && wb_dat_i[7:0] != `AWH_PRESCALE_ZERO) begin
      wake_prescale_q <= wb_dat_i[7:0];
    end
  end

  // set wins over a read clear in the same cycle; writes never touch it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_flag_q <= 1'b0;
    end else begin
      wake_flag_q <= (wake_flag_q && !rd_clr_w) || expire_w;
    end
  end

  // ----------------------------------------
  // wake oscillator and counter
  // ----------------------------------------
  // the oscillator input is taken as synchronous, so a plain edge detect is enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= wake_osc_clock_i;
    end
  end

  assign tick_w = wake_osc_clock_i && !osc_q;
  assign in_awh_w = (state_q == awh_pkg::st_awh);

  awh_wake_divider u_divider (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(in_awh_w),
    .tick_i(tick_w),
    .prescale_i(wake_prescale_q),
    .expire_o(expire_w)
  );

  assign wake_osc_en_o = in_awh_w || measure_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      capture_q <= 1'b0;
    end else begin
      capture_q <= measure_q && (state_q == awh_pkg::st_run) && wake_osc_clock_i;
    end
  end

  assign capture_clk_o = capture_q;

  // ----------------------------------------
  // halt sequencing
  // ----------------------------------------
  assign wdg_trip_w = watchdog_en_i && !watchdog_halt_option_i;

  always_comb begin
    state_d = state_q;
    case (state_q)
      awh_pkg::st_run: begin
        if (halt_exec_i && !wdg_trip_w) begin
          if (irq_pending_i) begin
            state_d = awh_pkg::st_stab;
          end else if (en_q) begin
            state_d = awh_pkg::st_awh;
          end else begin
            state_d = awh_pkg::st_halt;
          end
        end
      end
      awh_pkg::st_awh: begin
        if (expire_w || exit_irq_i) begin
          state_d = awh_pkg::st_stab;
        end
      end
      awh_pkg::st_halt: begin
        if (exit_irq_i) begin
          state_d = awh_pkg::st_stab;
        end
      end
      awh_pkg::st_stab: begin
        if (wait_cnt_q == StabLast) begin
          state_d = pll_en_i ? awh_pkg::st_pll : awh_pkg::st_run;
        end
      end
      awh_pkg::st_pll: begin
        if (wait_cnt_q == PllLast) begin
          state_d = awh_pkg::st_run;
        end
      end
      default: begin
        state_d = awh_pkg::st_run;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= awh_pkg::st_run;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_d != state_q) begin
      wait_cnt_q <= 9'h000;
    end else if (state_q == awh_pkg::st_stab || state_q == awh_pkg::st_pll) begin
      wait_cnt_q <= wait_cnt_q + 9'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_clr_q <= 1'b0;
      wdg_rst_q <= 1'b0;
    end else begin
      mask_clr_q <= (state_q == awh_pkg::st_run) && halt_exec_i && !wdg_trip_w;
      wdg_rst_q <= (state_q == awh_pkg::st_run) && halt_exec_i && wdg_trip_w;
    end
  end

  // ----------------------------------------
  // core facing outputs
  // ----------------------------------------
  // interrupt is only offered once the main clock has settled
  assign main_osc_en_o = !(state_q == awh_pkg::st_awh || state_q == awh_pkg::st_halt);
  assign periph_clk_en_o = main_osc_en_o;
  assign core_run_o = (state_q == awh_pkg::st_run);
  assign pll_ready_o = pll_en_i && core_run_o;
  assign auto_wake_halt_mode_o = in_awh_w;
  assign wake_irq_o = wake_flag_q && core_run_o;
  assign int_mask_clear_o = mask_clr_q;
  assign watchdog_reset_o = wdg_rst_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // a counter keeps the stabilise check free of a 256-long repetition
  logic [8:0] stab_seen_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != awh_pkg::st_stab) begin
      stab_seen_q <= 9'h000;
    end else begin
      stab_seen_q <= stab_seen_q + 9'h001;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_halt_entry_awh: assert property (
    core_run_o && halt_exec_i && en_q && !wdg_trip_w && !irq_pending_i
    |=> auto_wake_halt_mode_o && int_mask_clear_o)
    else $error("auto-wake halt not entered");
  a_osc_in_halt: assert property (auto_wake_halt_mode_o |-> wake_osc_en_o && !main_osc_en_o)
    else $error("oscillator state wrong in halt");
  a_expire_flag: assert property (auto_wake_halt_mode_o && expire_w |=> wake_flag_q && main_osc_en_o)
    else $error("expiry did not set flag and wake");
  a_stab_length: assert property ($fell(state_q == awh_pkg::st_stab) |-> stab_seen_q == 9'h100)
    else $error("stabilisation not 256 cycles");
  a_no_early_irq: assert property (expire_w |=> !wake_irq_o [*8])
    else $error("interrupt offered before run");
  a_read_clear: assert property (rd_clr_w && !expire_w |=> !wake_flag_q)
    else $error("read did not clear flag");
  a_flag_write_keep: assert property (wr_w && !expire_w && !rd_clr_w |=> $stable(wake_flag_q))
    else $error("write changed flag");
  a_pending_wake: assert property (
    core_run_o && halt_exec_i && !wdg_trip_w && irq_pending_i |=> main_osc_en_o && !core_run_o)
    else $error("pending interrupt did not wake at once");
  a_exit_irq: assert property (auto_wake_halt_mode_o && exit_irq_i |=> main_osc_en_o)
    else $error("exit interrupt ignored");
  a_wdg_reset: assert property (core_run_o && halt_exec_i && wdg_trip_w |=> watchdog_reset_o && core_run_o)
    else $error("watchdog reset missing");
  a_zero_keep: assert property (
    wr_w && hit_reg(wb_adr_i, `AWH_PRESCALE_IDX) && wb_dat_i[7:0] == 8'h00 |=> $stable(wake_prescale_q))
    else $error("zero prescale accepted");
  a_pll_wait: assert property ($rose(state_q == awh_pkg::st_pll) |-> !core_run_o [*8])
    else $error("core ran during multiplier start");
  a_irq_after_stab: assert property (
    $fell(state_q == awh_pkg::st_stab) && !pll_en_i && wake_flag_q |-> wake_irq_o)
    else $error("interrupt not offered after stabilise");
  a_capture_gate: assert property (!(measure_q && core_run_o) |=> !capture_clk_o)
    else $error("capture clock outside measurement");
  a_prescale_nonzero: assert property (wake_prescale_q != 8'h00)
    else $error("prescale holds zero");

  c_timer_wake: cover property (auto_wake_halt_mode_o ##1 expire_w ##[1:300] core_run_o);
  c_irq_wake: cover property (auto_wake_halt_mode_o && exit_irq_i);
  c_wdg_trip: cover property (watchdog_reset_o);
  c_read_clear: cover property (wake_flag_q && rd_clr_w);
  c_pll_wake: cover property ($rose(state_q == awh_pkg::st_pll));

endmodule

`default_nettype wire

// File: design/awh_cfg.svh
`ifndef AWH_CFG_SVH
`define AWH_CFG_SVH

// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define AWH_PRESCALE_IDX 7'h49
`define AWH_CSR_IDX 7'h4a
`define AWH_PRESCALE_RST 8'hff
`define AWH_CSR_RST 8'h00
`define AWH_PRESCALE_ZERO 8'h00

// ----------------------------------------
// control/status field positions
// ----------------------------------------
`define AWH_CSR_EN_BIT 0
`define AWH_CSR_MEAS_BIT 1
`define AWH_CSR_FLAG_BIT 2

// ----------------------------------------
// timing
// ----------------------------------------
`define AWH_FIXED_DIV 64
`define AWH_STAB_CYCLES 256
`define AWH_CLK_PERIOD_NS 100
`define AWH_PLL_START_NS 2000
`define AWH_PLL_START_CYCLES ((`AWH_PLL_START_NS + `AWH_CLK_PERIOD_NS - 1) / `AWH_CLK_PERIOD_NS)

`endif

// File: design/awh_pkg.sv
package awh_pkg;

  typedef enum logic [2:0] {
    st_run,
    st_awh,
    st_halt,
    st_stab,
    st_pll
  } awh_state_type;

endpackage

// File: design/awh_wake_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "awh_cfg.svh"

module awh_wake_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [7:0] prescale_i,
  output logic expire_o
);

  localparam logic [5:0] DivLast = 6'(`AWH_FIXED_DIV - 1);

  logic [5:0] div_q;
  logic [7:0] pre_q;
  logic last_w;

  // ----------------------------------------
  // fixed divide then programmable divide
  // ----------------------------------------
  // counts start from zero on every halt entry and are held cleared in run mode
  assign last_w = run_i && tick_i && (div_q == DivLast) && (pre_q == prescale_i - 8'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      div_q <= 6'h00;
      pre_q <= 8'h00;
    end else if (tick_i) begin
      div_q <= div_q + 6'h01;
      if (div_q == DivLast) begin
        pre_q <= last_w ? 8'h00 : pre_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= last_w;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_div_restart: assert property (!run_i |=> (div_q == 6'h00) && (pre_q == 8'h00))
    else $error("divider not cleared outside halt");
  a_div_expire: assert property (expire_o |-> $past(div_q) == DivLast && $past(tick_i))
    else $error("expiry without completed fixed divide");

endmodule

`default_nettype wire

// File: test/awh_core_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// core side: halt opcode, interrupt lines and the wake rc oscillator
// ----------------------------------------
module awh_core_model (
  input wire logic clk_i,
  input wire logic wake_osc_en_i,
  input wire logic auto_wake_i,
  output logic halt_exec_o,
  output logic irq_pending_o,
  output logic exit_irq_o,
  output logic wake_osc_clock_o
);
  localparam int rc_half = 4;
  int div = 0;
  int rc_rises = 0;

  initial begin
    halt_exec_o = 1'b0;
    irq_pending_o = 1'b0;
    exit_irq_o = 1'b0;
    wake_osc_clock_o = 1'b0;
  end

  // rc clock stands still while the oscillator is off, so no stale edges
  always @(posedge clk_i) begin
    if (wake_osc_en_i !== 1'b1) begin
      div <= 0;
      wake_osc_clock_o <= 1'b0;
    end else begin
      div <= (div + 1) % rc_half;
      if (div == rc_half - 1) begin
        wake_osc_clock_o <= ~wake_osc_clock_o;
        if (!wake_osc_clock_o && auto_wake_i) begin
          rc_rises <= rc_rises + 1;
        end
      end
    end
  end

  task automatic do_halt();
    halt_exec_o <= 1'b1;
    @(posedge clk_i);
    halt_exec_o <= 1'b0;
  endtask

  task automatic set_irq(input logic pend, input logic ext);
    irq_pending_o <= pend;
    exit_irq_o <= ext;
  endtask
endmodule

`default_nettype wire

// File: test/auto_wakeup_from_halt_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "awh_cfg.svh"

module auto_wakeup_from_halt_timer_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [8:0] adr = 9'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, halt_exec, irq_pending, exit_irq, rc_clk;
  logic wd_en = 1'b0, wd_opt = 1'b0, pll_en = 1'b0;
  logic wake_osc_en_o, main_osc_en_o, periph_clk_en_o, core_run_o, pll_ready_o;
  logic auto_wake_halt_mode_o, wake_irq_o, int_mask_clear_o, watchdog_reset_o;
  logic capture_clk_o, cap_prev = 1'b0;
  int fail_count = 0, compares = 0, stab_cnt = 0, cap_rises = 0;
  int m_pre = 8'hff, m_csr = 0, p, rc0;

  awh_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .halt_exec_i(halt_exec), .irq_pending_i(irq_pending), .exit_irq_i(exit_irq),
    .watchdog_en_i(wd_en), .watchdog_halt_option_i(wd_opt), .pll_en_i(pll_en),
    .wake_osc_clock_i(rc_clk), .wake_osc_en_o(wake_osc_en_o), .main_osc_en_o(main_osc_en_o),
    .periph_clk_en_o(periph_clk_en_o), .core_run_o(core_run_o), .pll_ready_o(pll_ready_o),
    .auto_wake_halt_mode_o(auto_wake_halt_mode_o), .wake_irq_o(wake_irq_o),
    .int_mask_clear_o(int_mask_clear_o), .watchdog_reset_o(watchdog_reset_o),
    .capture_clk_o(capture_clk_o));

  awh_core_model core (.clk_i(clk_i), .wake_osc_en_i(wake_osc_en_o),
    .auto_wake_i(auto_wake_halt_mode_o), .halt_exec_o(halt_exec), .irq_pending_o(irq_pending),
    .exit_irq_o(exit_irq), .wake_osc_clock_o(rc_clk));

  initial begin
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (main_osc_en_o === 1'b1 && core_run_o === 1'b0) stab_cnt <= stab_cnt + 1;
    if (capture_clk_o === 1'b1 && cap_prev === 1'b0) cap_rises <= cap_rises + 1;
    cap_prev <= capture_clk_o;
  end

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // register bus and reference model
  // ----------------------------------------
  task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d,
                      input logic s0);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'b000, s0};
    dat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      final_report();
    end
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] d, input logic s0);
    xfer(1'b1, idx, d, s0);
    if (s0 && idx == `AWH_PRESCALE_IDX && d != 0) m_pre = d;
    if (s0 && idx == `AWH_CSR_IDX) m_csr = (m_csr & 4) | (d & 3);
  endtask

  task automatic rd(input logic [6:0] idx);
    int e;
    xfer(1'b0, idx, 8'h00, 1'b1);
    e = idx == `AWH_PRESCALE_IDX ? m_pre : (idx == `AWH_CSR_IDX ? m_csr : 0);
    check("read data", q, 32'(e));
    if (idx == `AWH_CSR_IDX) m_csr = m_csr & 3;
  endtask

  task automatic wait_core(input int lim);
    int n;
    n = 0;
    while (core_run_o !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      final_report();
    end
  endtask

  task automatic halt_now();
    stab_cnt = 0;
    rc0 = core.rc_rises;
    core.do_halt();
    @(posedge clk_i);
    check("mask clear", int_mask_clear_o, 1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    void'($urandom(12));
    rd(`AWH_PRESCALE_IDX);
    rd(`AWH_CSR_IDX);
    rd(7'h10);
    wr(`AWH_PRESCALE_IDX, `AWH_PRESCALE_ZERO, 1'b1);
    rd(`AWH_PRESCALE_IDX);
    wr(`AWH_PRESCALE_IDX, 8'h12, 1'b0);
    wr(`AWH_CSR_IDX, 8'h04, 1'b1);
    rd(`AWH_CSR_IDX);
    $display("test registers done");
    wr(`AWH_CSR_IDX, 8'h02, 1'b1);
    check("osc on", wake_osc_en_o, 1);
    p = 0;
    while (!(core.div == core.rc_half - 1 && rc_clk === 1'b0) && p < 20) begin
      @(posedge clk_i);
      p++;
    end
    if (p >= 20) begin
      fail_count++;
      final_report();
    end
    cap_rises = 0;
    repeat (160) @(posedge clk_i);
    check("capture rises", cap_rises, 160 / (2 * core.rc_half));
    wr(`AWH_CSR_IDX, 8'h01, 1'b1);
    check("osc idle", wake_osc_en_o, 0);
    $display("test measure done");
    // an aborted halt must not leave a partial count behind
    halt_now();
    repeat (100) @(posedge clk_i);
    core.set_irq(1'b0, 1'b1);
    wait_core(400);
    core.set_irq(1'b0, 1'b0);
    rd(`AWH_CSR_IDX);
    for (int i = 0; i < 2; i++) begin
      p = $urandom_range(3, 1);
      wr(`AWH_PRESCALE_IDX, 8'(p), 1'b1);
      halt_now();
      check("halt mode", {auto_wake_halt_mode_o, main_osc_en_o, periph_clk_en_o}, 4);
      check("rc on", {wake_osc_en_o, core_run_o}, 2);
      wait_core(`AWH_FIXED_DIV * p * 2 * core.rc_half + 400);
      check("rc edges", core.rc_rises - rc0, `AWH_FIXED_DIV * p);
      check("stabilise", stab_cnt, `AWH_STAB_CYCLES);
      check("wake irq", wake_irq_o, 1);
      m_csr = m_csr | 4;
      rd(`AWH_CSR_IDX);
      check("irq cleared", wake_irq_o, 0);
    end
    $display("test auto wake done");
    wr(`AWH_CSR_IDX, 8'h00, 1'b1);
    halt_now();
    repeat (1000) @(posedge clk_i);
    check("plain halt", {auto_wake_halt_mode_o, wake_osc_en_o, core_run_o}, 0);
    core.set_irq(1'b0, 1'b1);
    wait_core(400);
    core.set_irq(1'b0, 1'b0);
    check("exit stab", stab_cnt, `AWH_STAB_CYCLES);
    wr(`AWH_CSR_IDX, 8'h01, 1'b1);
    core.set_irq(1'b1, 1'b0);
    halt_now();
    check("pending", {main_osc_en_o, core_run_o}, 2);
    wait_core(400);
    core.set_irq(1'b0, 1'b0);
    check("pending stab", stab_cnt, `AWH_STAB_CYCLES);
    $display("test halt exits done");
    wd_en <= 1'b1;
    core.do_halt();
    @(posedge clk_i);
    check("watchdog", {watchdog_reset_o, core_run_o}, 3);
    wd_opt <= 1'b1;
    pll_en <= 1'b1;
    wr(`AWH_PRESCALE_IDX, 8'h01, 1'b1);
    halt_now();
    check("halt kept", auto_wake_halt_mode_o, 1);
    wait_core(2000);
    check("pll stab", stab_cnt, `AWH_STAB_CYCLES + `AWH_PLL_START_CYCLES);
    check("pll ready", pll_ready_o, 1);
    m_csr = m_csr | 4;
    rd(`AWH_CSR_IDX);
    $display("test watchdog and multiplier done");
    // a reset in mid halt brings the core back to run with registers at reset values
    wr(`AWH_CSR_IDX, 8'h01, 1'b1);
    halt_now();
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset exit", {auto_wake_halt_mode_o, core_run_o, main_osc_en_o}, 3);
    m_pre = 8'hff;
    m_csr = 0;
    rd(`AWH_PRESCALE_IDX);
    rd(`AWH_CSR_IDX);
    $display("test reset exit done");
    final_report();
  end
endmodule

`default_nettype wire
